// >>> logic/smbsl_link_shift.sv
// serial data capture on the bus clock itself
// assumes data is stable while the bus clock is high, so the rising edge samples it
`timescale 1ns/100ps
`default_nettype none

module smbsl_link_shift (
  // link clock and reset
  input  wire logic       scl_clk_in,
  input  wire logic       sys_rst_in,
  // serial data
  input  wire logic       sda_in,
  // last eight bits, newest in bit 0
  output var  logic [7:0] shift_out
);

  // msb arrives first, so after eight edges bit 7 holds the first bit
  always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_out <= 8'h00;
    end else begin
      shift_out <= {shift_out[6:0], sda_in};
    end
  end

endmodule

`default_nettype wire

// >>> logic/smbsl_map.svh
// constants of the bus slave front end: addresses, config bit, byte framing, timeout
// assumes nothing; definitions only, included by bare name
`ifndef SMBSL_MAP_SVH
`define SMBSL_MAP_SVH

// slave addresses chosen by the straps
`define SMBSL_ADDR_FIXED    7'h2e
`define SMBSL_ADDR_SEL_LOW  7'h2c
`define SMBSL_ADDR_SEL_HIGH 7'h2d

// configuration register holding the timeout disable bit, and its reset value
`define SMBSL_CFG_TIMEOUT_REG 8'h11
`define SMBSL_TIMEOUT_DIS_BIT 4
`define SMBSL_TIMEOUT_DIS_RST 1'h0

// byte framing: rise count at the last data bit and at the acknowledge bit
`define SMBSL_LAST_DATA_RISE 4'h8
`define SMBSL_ACK_RISE       4'h9

// bus idle timeout, in ms, and the core clock rate in kHz
`define SMBSL_TIMEOUT_MS   35
`define SMBSL_CORE_CLK_KHZ 250000

`endif

// >>> logic/smbsl_pkg.sv
// types shared by the bus slave front end
// assumes the constants header is compiled alongside
package smbsl_pkg;

  typedef enum logic [6:0] {
    SMBSL_IDLE   = 7'h01,
    SMBSL_ADDR   = 7'h02,
    SMBSL_WPTR   = 7'h04,
    SMBSL_WDATA  = 7'h08,
    SMBSL_WDONE  = 7'h10,
    SMBSL_RDATA  = 7'h20,
    SMBSL_IGNORE = 7'h40
  } smbsl_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } smbsl_wr_type;

endpackage

// >>> logic/smbsl_slave.sv
// bus slave front end: address match, pointer and register byte transfers, bus timeout
// assumes straps and bus pins are asynchronous; register file sits on core_clk_in
//
// Summary of operation
// - address enable strap high: answer slave address 0x2e.
// - strap low: select strap picks 0x2c when low, 0x2d when high.
// - both strap levels are sampled from powerup.
// - address follows straps until latched at eighth rise of first matching byte.
// - once latched, strap changes are ignored until next powerup.
// - each byte is eight bits msb first plus one acknowledge bit.
// - data changes only while clock low; rising data with clock high is stop.
// - read/write bit fixes direction; only a new start changes it.
// - writes carry one or two bytes; reads return exactly one byte.
// - first write byte always goes to the address pointer.
// - second write byte goes to the register the pointer selects.
// - pointer-only write changes no data register.
// - read returns the register the pointer selects, no pointer write needed.
// - pointer write, repeated start, one-byte read is supported.
// - repeated start is recognised and a new address byte decoded.
// - 35 ms without bus activity mid-transfer releases data and returns idle.
// - bit 4 of register 0x11 disables the timeout; resets to enabled.
`include "smbsl_map.svh"
`timescale 1ns/100ps
`default_nettype none

module smbsl_slave import smbsl_pkg::*; #(
  parameter int TIMEOUT_CYCLES = `SMBSL_TIMEOUT_MS * `SMBSL_CORE_CLK_KHZ
) (
  // clocks and reset
  input  wire logic         core_clk_in,
  input  wire logic         scl_clk_in,
  input  wire logic         sys_rst_in,
  // bus pins; data is open drain
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output var  logic         sda_out,
  output var  logic         sda_oe_out,
  // address straps
  input  wire logic         address_strap_enable_in,
  input  wire logic         address_select_in,
  // register file side
  output var  logic [7:0]   reg_ptr_out,
  input  wire logic [7:0]   reg_rd_data_in,
  output var  smbsl_wr_type reg_wr_out,
  // status
  output var  logic         bus_timeout_disable_out,
  output var  logic [6:0]   slave_addr_out,
  output var  logic         addr_locked_out
);

  initial begin
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 16777215) begin
      $error("TIMEOUT_CYCLES out of range");
    end
  end

  localparam logic [23:0] TO_LAST = 24'(TIMEOUT_CYCLES - 1);

  logic            scl_s1, scl_s2, scl_d;
  logic            sda_s1, sda_s2, sda_d;
  logic            en_s1, en_s2, sel_s1, sel_s2;
  logic [7:0]      shift_word;
  smbsl_state_type state;
  logic [3:0]      bit_cnt;
  logic            ack_pending;
  logic [7:0]      tx;
  logic [23:0]     to_cnt;
  logic            scl_rise, scl_fall, start_cond, stop_cond, timeout_hit;
  logic            byte_done, ack_rise, addr_match;
  logic [6:0]      next_strap_addr;

  smbsl_link_shift u_shift (
    .scl_clk_in (scl_clk_in),
    .sys_rst_in (sys_rst_in),
    .sda_in     (sda_in),
    .shift_out  (shift_word)
  );

  // pin synchronisers; first stages feed only the second
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
      {en_s1, en_s2, sel_s1, sel_s2} <= 4'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      en_s1  <= address_strap_enable_in;
      en_s2  <= en_s1;
      sel_s1 <= address_select_in;
      sel_s2 <= sel_s1;
    end
  end

  assign scl_rise   = scl_s2 & ~scl_d;
  assign scl_fall   = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign byte_done  = scl_rise && (bit_cnt == `SMBSL_LAST_DATA_RISE - 4'h1);
  assign ack_rise   = scl_rise && (bit_cnt == `SMBSL_ACK_RISE - 4'h1);
  assign addr_match = (shift_word[7:1] == slave_addr_out);
  assign timeout_hit = (to_cnt == TO_LAST) && !bus_timeout_disable_out
                       && (state != SMBSL_IDLE);
  assign next_strap_addr = en_s2  ? `SMBSL_ADDR_FIXED :
                           sel_s2 ? `SMBSL_ADDR_SEL_HIGH :
                                    `SMBSL_ADDR_SEL_LOW;

  // address follows the synchronised straps until the first match freezes it
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      slave_addr_out  <= `SMBSL_ADDR_FIXED;
      addr_locked_out <= 1'h0;
    end else if (!addr_locked_out) begin
      slave_addr_out <= next_strap_addr;
      if (state == SMBSL_ADDR && byte_done && addr_match) begin
        addr_locked_out <= 1'h1;
        slave_addr_out  <= slave_addr_out;
      end
    end
  end

  // bit counter: rises 1..8 are data, 9 is acknowledge
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt <= 4'h0;
    end else if (start_cond) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt <= (bit_cnt == `SMBSL_ACK_RISE) ? 4'h1 : bit_cnt + 4'h1;
    end
  end

  // transfer state
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state       <= SMBSL_IDLE;
      ack_pending <= 1'h0;
    end else if (start_cond) begin
      state       <= SMBSL_ADDR;
      ack_pending <= 1'h0;
    end else if (stop_cond || timeout_hit) begin
      state       <= SMBSL_IDLE;
      ack_pending <= 1'h0;
    end else if (byte_done) begin
      case (state)
        SMBSL_ADDR: begin
          if (addr_match) begin
            state       <= shift_word[0] ? SMBSL_RDATA : SMBSL_WPTR;
            ack_pending <= 1'h1;
          end else begin
            state <= SMBSL_IGNORE;
          end
        end
        SMBSL_WPTR: begin
          state       <= SMBSL_WDATA;
          ack_pending <= 1'h1;
        end
        SMBSL_WDATA: begin
          state       <= SMBSL_WDONE;
          ack_pending <= 1'h1;
        end
        SMBSL_WDONE: begin
          // a third write byte is refused
          state <= SMBSL_IGNORE;
        end
        default: begin
          state <= state;
        end
      endcase
    end else if (ack_rise && state == SMBSL_RDATA && !ack_pending) begin
      // one byte only, whatever the master answers; the address ack slot still
      // has ack_pending set, so only the data byte's ack slot ends the read
      state <= SMBSL_IGNORE;
    end else if (scl_fall && bit_cnt == `SMBSL_ACK_RISE) begin
      ack_pending <= 1'h0;
    end
  end

  // pointer, register writes and the local copy of the timeout disable
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_ptr_out             <= 8'h00;
      reg_wr_out              <= '0;
      bus_timeout_disable_out <= `SMBSL_TIMEOUT_DIS_RST;
    end else begin
      reg_wr_out.valid <= 1'h0;
      if (byte_done && state == SMBSL_WPTR) begin
        reg_ptr_out <= shift_word;
      end
      if (byte_done && state == SMBSL_WDATA) begin
        reg_wr_out.valid <= 1'h1;
        reg_wr_out.addr  <= reg_ptr_out;
        reg_wr_out.data  <= shift_word;
        if (reg_ptr_out == `SMBSL_CFG_TIMEOUT_REG) begin
          bus_timeout_disable_out <= shift_word[`SMBSL_TIMEOUT_DIS_BIT];
        end
      end
    end
  end

  // data pin drive; changes follow a falling clock edge, but start, stop and timeout release it at once
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_oe_out <= 1'h0;
      sda_out    <= 1'h0;
      tx         <= 8'h00;
    end else if (start_cond || stop_cond || timeout_hit) begin
      sda_oe_out <= 1'h0;
    end else if (scl_fall) begin
      if (bit_cnt == `SMBSL_LAST_DATA_RISE) begin
        sda_oe_out <= ack_pending;
      end else if (bit_cnt == `SMBSL_ACK_RISE && state == SMBSL_RDATA) begin
        // register data is on the core clock, so it is taken as the byte starts
        tx         <= reg_rd_data_in;
        sda_oe_out <= ~reg_rd_data_in[7];
      end else if (bit_cnt == `SMBSL_ACK_RISE) begin
        sda_oe_out <= 1'h0;
      end else if (state == SMBSL_RDATA && bit_cnt != 4'h0) begin
        tx         <= {tx[6:0], 1'h0};
        sda_oe_out <= ~tx[6];
      end
    end
  end

  // bus activity watchdog
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      to_cnt <= 24'h000000;
    end else if (state == SMBSL_IDLE || scl_s2 != scl_d || sda_s2 != sda_d
                 || to_cnt == TO_LAST) begin
      to_cnt <= 24'h000000;
    end else begin
      to_cnt <= to_cnt + 24'h000001;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_fixed_addr: assert property (!addr_locked_out && en_s2 && !byte_done
    |=> slave_addr_out == `SMBSL_ADDR_FIXED) else $error("fixed address not selected");
  a_select_addr: assert property (!addr_locked_out && !en_s2 && !byte_done
    |=> slave_addr_out == ($past(sel_s2) ? `SMBSL_ADDR_SEL_HIGH : `SMBSL_ADDR_SEL_LOW))
    else $error("select address wrong");
  a_lock_moment: assert property ($rose(addr_locked_out)
    |-> $past(byte_done) && $past(state) == SMBSL_ADDR) else $error("address latched off edge");
  a_lock_hold: assert property (addr_locked_out
    |=> addr_locked_out && $stable(slave_addr_out)) else $error("latched address moved");
  a_ack_low_clock: assert property ($rose(sda_oe_out) |-> !scl_s2 && !scl_d)
    else $error("data driven while clock high");
  a_ptr_store: assert property (byte_done && state == SMBSL_WPTR && !start_cond
    |=> reg_ptr_out == $past(shift_word) && !reg_wr_out.valid) else $error("pointer not stored");
  a_wr_target: assert property (reg_wr_out.valid
    |-> reg_wr_out.addr == reg_ptr_out && state == SMBSL_WDONE) else $error("bad write target");
  a_ptr_only: assert property (state == SMBSL_WPTR |-> !reg_wr_out.valid)
    else $error("pointer-only write changed data");
  a_read_once: assert property (ack_rise && state == SMBSL_RDATA && !stop_cond
    && !ack_pending && !timeout_hit && !start_cond |=> state == SMBSL_IGNORE)
    else $error("read ran past one byte");
  a_foreign_nack: assert property (byte_done && state == SMBSL_ADDR && !addr_match
    |=> state == SMBSL_IGNORE ##0 !sda_oe_out [*8]) else $error("foreign address answered");
  a_restart: assert property (start_cond |=> state == SMBSL_ADDR && bit_cnt == 4'h0
    && !sda_oe_out) else $error("start not recognised");
  a_timeout_release: assert property (timeout_hit
    |=> state == SMBSL_IDLE && !sda_oe_out) else $error("timeout did not release");
  a_ack_drive: assert property (scl_fall && bit_cnt == `SMBSL_LAST_DATA_RISE
    && ack_pending && !start_cond && !stop_cond && !timeout_hit |=> sda_oe_out)
    else $error("acknowledge not driven");

  c_data_write: cover property (reg_wr_out.valid);
  c_byte_read: cover property (ack_rise && state == SMBSL_RDATA && !ack_pending);
  c_repeated_start: cover property (start_cond && state == SMBSL_WDATA);
  c_timeout: cover property (timeout_hit);

endmodule

`default_nettype wire

// >>> sim/smbsl_host.sv
// bus master model: start, repeated start, stop, byte send and receive
// assumes a pull-up on data outside; the clock stands high between frames
`timescale 1ns/100ps
`default_nettype none

module smbsl_host (
  // bus pins
  output var  logic scl_out,
  output var  logic sda_oe_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // one 30 ns pulse with a long low phase: the slave answers 8 to 12 ns after
  // the fall, so 22.5 ns low keeps its data change inside the low time
  task automatic bit_clk(input logic b, output logic s);
    #6 sda_oe_out = ~b;
    #16.5 scl_out = 1'b1;
    #7 s = sda_in;
    #0.5 scl_out = 1'b0;
  endtask

  // also serves as repeated start; waits out the slave's ack release first
  task automatic start();
    #20 sda_oe_out = 1'b0;
    #10 scl_out = 1'b1;
    #60 sda_oe_out = 1'b1;
    #60 scl_out = 1'b0;
  endtask

  task automatic stop();
    #7.5 sda_oe_out = 1'b1;
    #7.5 scl_out = 1'b1;
    #60 sda_oe_out = 1'b0;
    #60;
  endtask

  task automatic send8(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_clk(v[i], s);
  endtask

  task automatic take_ack(output logic a);
    bit_clk(1'b1, a);
  endtask

  task automatic recv8(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_clk(1'b1, v[i]);
    bit_clk(1'b1, s);
  endtask
endmodule

`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench of the bus slave front end with a bus master model
// assumes the slave's data drive is open drain onto a pulled-up line
`timescale 1ns/100ps
`default_nettype none

module testbench import smbsl_pkg::*;;
  localparam int TO = 200;
  logic         core_clk, rst, en, sel, scl, host_oe, dev_oe, dev_sda, tod, locked;
  wire          sda;
  logic [7:0]   ptr, rd_data;
  logic [6:0]   saddr;
  smbsl_wr_type wr;
  logic [7:0]   regs [256];
  int           wr_cnt = 0;
  int           bad_count = 0;
  int           n_checks = 0;

  smbsl_slave #(.TIMEOUT_CYCLES(TO)) smbsl_slave_i (
    .core_clk_in(core_clk), .scl_clk_in(scl), .sys_rst_in(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(dev_sda), .sda_oe_out(dev_oe),
    .address_strap_enable_in(en), .address_select_in(sel),
    .reg_ptr_out(ptr), .reg_rd_data_in(rd_data), .reg_wr_out(wr),
    .bus_timeout_disable_out(tod), .slave_addr_out(saddr), .addr_locked_out(locked));
  smbsl_host smbsl_host_i (.scl_out(scl), .sda_oe_out(host_oe), .sda_in(sda));

  assign sda = (dev_oe ? dev_sda : 1'b1) & ~host_oe;
  assign rd_data = regs[ptr];
  always @(posedge core_clk) begin
    if (wr.valid === 1'b1) begin
      regs[wr.addr] <= wr.data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset(input logic e, input logic s);
    @(posedge core_clk);
    rst <= 1'b1;
    en <= e;
    sel <= s;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic addr_probe(input logic [6:0] a7, output logic a);
    smbsl_host_i.start();
    smbsl_host_i.send8({a7, 1'b0});
    smbsl_host_i.take_ack(a);
    smbsl_host_i.stop();
  endtask

  // acks: bit 0 address, bit 1 pointer, bit 2 data; rs leaves the frame open
  task automatic wr_frame(input logic [7:0] p, input logic n, input logic [7:0] d,
                          input logic rs, output logic [2:0] a);
    a = 3'h0;
    smbsl_host_i.start();
    smbsl_host_i.send8(8'h5c);
    smbsl_host_i.take_ack(a[0]);
    smbsl_host_i.send8(p);
    smbsl_host_i.take_ack(a[1]);
    if (n) begin
      smbsl_host_i.send8(d);
      smbsl_host_i.take_ack(a[2]);
    end
    if (!rs) smbsl_host_i.stop();
  endtask

  task automatic rd_frame(output logic [7:0] v, output logic a);
    smbsl_host_i.start();
    smbsl_host_i.send8(8'h5d);
    smbsl_host_i.take_ack(a);
    smbsl_host_i.recv8(v);
    smbsl_host_i.stop();
  endtask

  task automatic t_addr();
    logic       a;
    logic [6:0] da;
    for (int k = 0; k < 3; k++) begin
      da = (k == 2) ? 7'h2e : ((k == 1) ? 7'h2d : 7'h2c);
      do_reset(k == 2, k != 1);
      sel <= (k == 1);
      repeat (8) @(posedge core_clk);
      chk("slave_addr", {1'b0, da}, {1'b0, saddr});
      addr_probe(7'h2f, a);
      chk("foreign_ack", 8'h01, {7'h0, a});
      chk("locked", 8'h00, {7'h0, locked});
      addr_probe(da, a);
      chk("own_ack", 8'h00, {7'h0, a});
      chk("locked", 8'h01, {7'h0, locked});
      en <= (k != 2);
      sel <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("slave_addr", {1'b0, da}, {1'b0, saddr});
      addr_probe((k != 2) ? 7'h2e : 7'h2c, a);
      chk("moved_ack", 8'h01, {7'h0, a});
    end
  endtask

  task automatic t_write();
    logic [2:0] a;
    int         n0;
    do_reset(1'b1, 1'b0);
    chk("timeout_disable", 8'h00, {7'h0, tod});
    n0 = wr_cnt;
    wr_frame(8'h11, 1'b1, 8'h10, 1'b0, a);
    chk("write_acks", 8'h00, {5'h0, a});
    chk("pointer", 8'h11, ptr);
    chk("reg_data", 8'h10, regs[8'h11]);
    chk("timeout_disable", 8'h01, {7'h0, tod});
    chk("write_count", 8'h01, 8'(wr_cnt - n0));
  endtask

  task automatic t_ptr_read();
    logic [2:0] a;
    logic [7:0] v;
    logic       b;
    int         n0;
    n0 = wr_cnt;
    regs[8'h05] = 8'ha5;
    wr_frame(8'h05, 1'b0, 8'h00, 1'b1, a);
    rd_frame(v, b);
    chk("pointer", 8'h05, ptr);
    chk("read_ack", 8'h00, {7'h0, b});
    chk("read_data", 8'ha5, v);
    chk("write_count", 8'h00, 8'(wr_cnt - n0));
    regs[8'h05] = 8'h3c;
    rd_frame(v, b);
    chk("read_data", 8'h3c, v);
  endtask

  task automatic t_timeout();
    logic [2:0] a;
    logic       b;
    do_reset(1'b1, 1'b0);
    smbsl_host_i.start();
    smbsl_host_i.send8(8'h5c);
    repeat (6) @(posedge core_clk);
    chk("ack_drive", 8'h01, {7'h0, dev_oe});
    repeat (TO + 10) @(posedge core_clk);
    chk("ack_drive", 8'h00, {7'h0, dev_oe});
    smbsl_host_i.stop();
    wr_frame(8'h11, 1'b1, 8'h10, 1'b0, a);
    smbsl_host_i.start();
    smbsl_host_i.send8(8'h5c);
    repeat (TO + 16) @(posedge core_clk);
    chk("ack_drive", 8'h01, {7'h0, dev_oe});
    smbsl_host_i.take_ack(b);
    smbsl_host_i.stop();
    chk("late_ack", 8'h00, {7'h0, b});
  endtask

  // a hang anywhere ends the run as a mismatch
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    en = 1'b1;
    sel = 1'b0;
    t_addr();
    t_write();
    t_ptr_read();
    t_timeout();
    end_sim();
  end
endmodule

`default_nettype wire
